// *** bus_host_model.sv ***
// Behavioural two-wire bus host, clock half period of four cycles.
// Assumes open-drain data with a pull-up; either side pulls low.
`timescale 1ns/1ps
module bus_host_model (
   input wire logic sys_clk_i,
   input wire logic sda_oe_i,
   output logic scl_o,
   output logic sda_o
);
   logic sda_q;
   assign sda_o = sda_q & ~sda_oe_i;
   initial begin
      scl_o = 1'b1;
      sda_q = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : tick
   task automatic frame(input logic stop);
      tick(1);
      sda_q <= ~stop;
      tick(3);
      scl_o <= 1'b1;
      tick(4);
      sda_q <= stop;
      tick(4);
      if (!stop) scl_o <= 1'b0;
   endtask : frame
   task automatic bit_io(input logic b, output logic r);
      tick(1);
      sda_q <= b;
      tick(3);
      scl_o <= 1'b1;
      tick(4);
      r = sda_o;
      scl_o <= 1'b0;
   endtask : bit_io
   task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
      output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(last, ack);
   endtask : xfer
endmodule : bus_host_model

// *** module_serial_id_memory.sv ***
// Two-wire serial identification memory with receive signal-lost output.
// Assumes host clocks the bus below 100 kHz; pins are asynchronous to sys_clk_i.
`timescale 1ns/1ps
`include "sid_defs.svh"

module module_serial_id_memory (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic present_n_o,
   input wire logic signal_lost_flag_i,
   output logic rx_signal_lost_output_o,
   output logic rx_signal_lost_oe_o
);

   // Bus pins reset to their idle high level, so no false edge after reset
   logic scl_s_q, sda_s_q, los_s_q;
   logic scl_p_q, scl_p_d, sda_p_q, sda_p_d;

   pin_sync #(.RST_VAL(`SID_PIN_IDLE)) scl_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .pin_i(scl_i),
      .sync_o(scl_s_q)
   );

   pin_sync #(.RST_VAL(`SID_PIN_IDLE)) sda_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .pin_i(sda_i),
      .sync_o(sda_s_q)
   );

   pin_sync #(.RST_VAL(`SID_LOS_IDLE)) los_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .pin_i(signal_lost_flag_i),
      .sync_o(los_s_q)
   );

   // Third flop only for edge and start/stop detection
   always_comb begin
      scl_p_d = scl_s_q;
      sda_p_d = sda_s_q;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         scl_p_q <= `SID_PIN_IDLE;
         sda_p_q <= `SID_PIN_IDLE;
      end else begin
         scl_p_q <= scl_p_d;
         sda_p_q <= sda_p_d;
      end
   end

   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise = scl_s_q & ~scl_p_q;
   assign scl_fall = ~scl_s_q & scl_p_q;
   assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   assign stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

   logic [7:0] mem_q [`SID_MEM_DEPTH];

   function automatic logic [7:0] rom_init(input logic [`SID_AW-1:0] a);
      logic [7:0] v;
      v = `SID_ZERO;
      case (a)
         `SID_OFF_TYPE: v = `SID_VAL_TYPE;
         `SID_OFF_EXT: v = `SID_VAL_EXT;
         `SID_OFF_CONN: v = `SID_VAL_CONN;
         `SID_OFF_ENC: v = `SID_VAL_ENC;
         `SID_OFF_RATE: v = `SID_VAL_RATE;
         `SID_OFF_RSVD13: v = `SID_ZERO;
         `SID_OFF_SM_KM: v = `SID_VAL_SM_KM;
         `SID_OFF_SM_100M: v = `SID_VAL_SM_100M;
         `SID_OFF_MMA: v = `SID_VAL_MMA;
         `SID_OFF_MMB: v = `SID_VAL_MMB;
         `SID_OFF_CU: v = `SID_VAL_CU;
         default: begin
            if (a >= `SID_OFF_COMPAT && a < `SID_OFF_ENC) begin
               v = 8'(`SID_VAL_COMPAT >> (8 * (7 - 32'(a - `SID_OFF_COMPAT))));
            end
         end
      endcase
      return v;
   endfunction

   sid_pkg::sid_state_e st_q, st_d;
   logic [7:0] sh_q, sh_d;
   logic [3:0] bit_q, bit_d;
   logic [`SID_AW-1:0] ptr_q, ptr_d;
   logic rd_q, rd_d;
   logic oe_q, oe_d;
   logic dout_q, dout_d;
   logic wr_en;
   logic [`SID_AW-1:0] wr_addr;

   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      bit_d = bit_q;
      ptr_d = ptr_q;
      rd_d = rd_q;
      oe_d = oe_q;
      dout_d = dout_q;
      wr_en = 1'b0;
      wr_addr = ptr_q;
      if (start_det) begin
         st_d = sid_pkg::ST_DEVADDR;
         bit_d = 4'h0;
         oe_d = 1'b0;
      end else if (stop_det) begin
         st_d = sid_pkg::ST_IDLE;
         oe_d = 1'b0;
      end else if (scl_rise) begin
         case (st_q)
            sid_pkg::ST_DEVADDR, sid_pkg::ST_ADDR, sid_pkg::ST_WDATA: begin
               sh_d = {sh_q[6:0], sda_s_q};
               bit_d = bit_q + 4'h1;
            end
            sid_pkg::ST_ACK_IN: begin
               if (sda_s_q) begin
                  st_d = sid_pkg::ST_IDLE;
               end
            end
            sid_pkg::ST_RDATA: begin
               bit_d = bit_q + 4'h1;
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (st_q)
            sid_pkg::ST_DEVADDR: begin
               if (bit_q == 4'h8) begin
                  if (sh_q[7:1] == `SID_DEV_ADDR) begin
                     rd_d = sh_q[0];
                     st_d = sid_pkg::ST_ACK_OUT;
                     oe_d = 1'b1;
                     dout_d = 1'b0;
                  end else begin
                     st_d = sid_pkg::ST_IDLE;
                  end
               end
            end
            sid_pkg::ST_ADDR: begin
               if (bit_q == 4'h8) begin
                  ptr_d = sh_q[`SID_AW-1:0];
                  st_d = sid_pkg::ST_ACK_OUT;
                  oe_d = 1'b1;
                  dout_d = 1'b0;
               end
            end
            sid_pkg::ST_WDATA: begin
               if (bit_q == 4'h8) begin
                  // protect id fields
                  // Acked either way; protected bytes simply stay
                  wr_en = (ptr_q > `SID_OFF_PROT_END);
                  ptr_d = ptr_q + 1'b1;
                  st_d = sid_pkg::ST_ACK_OUT;
                  oe_d = 1'b1;
                  dout_d = 1'b0;
               end
            end
            sid_pkg::ST_ACK_OUT: begin
               bit_d = 4'h0;
               if (rd_q) begin
                  st_d = sid_pkg::ST_RDATA;
                  sh_d = mem_q[ptr_q];
                  oe_d = ~mem_q[ptr_q][7];
                  dout_d = 1'b0;
               end else begin
                  oe_d = 1'b0;
                  st_d = sid_pkg::ST_WDATA;
               end
            end
            sid_pkg::ST_RDATA: begin
               if (bit_q == 4'h8) begin
                  ptr_d = ptr_q + 1'b1;
                  st_d = sid_pkg::ST_ACK_IN;
                  oe_d = 1'b0;
               end else begin
                  sh_d = {sh_q[6:0], 1'b0};
                  oe_d = ~sh_q[6];
               end
            end
            sid_pkg::ST_ACK_IN: begin
               bit_d = 4'h0;
               st_d = sid_pkg::ST_RDATA;
               sh_d = mem_q[ptr_q];
               oe_d = ~mem_q[ptr_q][7];
            end
            default: begin
            end
         endcase
      end
      wr_addr = ptr_q;
      dout_d = ~oe_d;
   end

   // First write after device address is the word address
   logic addr_phase_q, addr_phase_d;
   always_comb begin
      addr_phase_d = addr_phase_q;
      if (start_det) begin
         addr_phase_d = 1'b1;
      end else if (scl_fall && st_q == sid_pkg::ST_ADDR && bit_q == 4'h8) begin
         addr_phase_d = 1'b0;
      end
   end

   sid_pkg::sid_state_e st_fix;
   always_comb begin
      st_fix = st_d;
      if (scl_fall && st_q == sid_pkg::ST_ACK_OUT && !rd_q && addr_phase_q) begin
         st_fix = sid_pkg::ST_ADDR;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= sid_pkg::ST_IDLE;
         sh_q <= 8'h00;
         bit_q <= 4'h0;
         ptr_q <= 7'h00;
         rd_q <= 1'b0;
         oe_q <= 1'b0;
         dout_q <= 1'b0;
         addr_phase_q <= 1'b0;
      end else begin
         st_q <= st_fix;
         sh_q <= sh_d;
         bit_q <= bit_d;
         ptr_q <= ptr_d;
         rd_q <= rd_d;
         oe_q <= oe_d;
         dout_q <= dout_d;
         addr_phase_q <= addr_phase_d;
      end
   end

   // unused text bytes default to zero; reserved stays zero
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < `SID_MEM_DEPTH; i++) begin
            mem_q[i] <= rom_init(7'(i));
         end
      end else if (wr_en) begin
         mem_q[wr_addr] <= sh_q;
      end
   end

   // Open drain: low only when driven
   assign sda_o = dout_q;
   assign sda_oe_o = oe_q;
   assign present_n_o = 1'b0;

   // Same filter both ways, so a short glitch never reaches the pin
   // loss output, bounded assert delay
   logic [`SID_LOS_CW-1:0] los_cnt_q, los_cnt_d;
   logic los_out_q, los_out_d;
   always_comb begin
      los_cnt_d = los_cnt_q;
      los_out_d = los_out_q;
      if (los_s_q == los_out_q) begin
         los_cnt_d = '0;
      end else if (los_cnt_q >= `SID_LOS_CW'(`SID_LOS_CYC)) begin
         los_out_d = los_s_q;
         los_cnt_d = '0;
      end else begin
         los_cnt_d = los_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         los_cnt_q <= '0;
         los_out_q <= 1'b0;
      end else begin
         los_cnt_q <= los_cnt_d;
         los_out_q <= los_out_d;
      end
   end

   // Open collector: high level means released
   assign rx_signal_lost_output_o = los_out_q;
   assign rx_signal_lost_oe_o = ~los_out_q;

endmodule : module_serial_id_memory

// Two-flop synchroniser for one asynchronous pin.
// Only the second flop reads the possibly metastable first one.
module pin_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic pin_i,
   output logic sync_o
);
   logic meta_q, meta_d, sync_q, sync_d;

   always_comb begin
      meta_d = pin_i;
      sync_d = meta_q;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_o = sync_q;

endmodule : pin_sync

// *** serial_id_checker.sv ***
// Port checker for the serial id memory block.
// Assumes sys_clk_i at 25 MHz and rst_i asynchronous, active high.
`timescale 1ns/1ps
module serial_id_checker (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic present_n_o,
   input wire logic signal_lost_flag_i,
   input wire logic rx_signal_lost_output_o,
   input wire logic rx_signal_lost_oe_o
);
   logic scl_q, scl_d;
   logic [11:0] fall_q, fall_d, on_q, on_d, off_q, off_d;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   always_comb begin
      scl_d = scl_i;
      // Saturate so long idle never wraps
      fall_d = (scl_q && !scl_i) ? 12'h000 : fall_q + {11'h000, fall_q < 12'h0ff};
      on_d = signal_lost_flag_i ? on_q + {11'h000, on_q < 12'hfff} : 12'h000;
      off_d = signal_lost_flag_i ? 12'h000 : off_q + {11'h000, off_q < 12'hfff};
   end
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         scl_q <= 1'b1;
         fall_q <= 12'h0ff;
         on_q <= 12'h000;
         off_q <= 12'h000;
      end else begin
         scl_q <= scl_d;
         fall_q <= fall_d;
         on_q <= on_d;
         off_q <= off_d;
      end
   end
   a_present_low: assert property (present_n_o == 1'b0)
      else $error("present indication not low");
   a_sda_drive_zero: assert property (sda_oe_o |-> !sda_o)
      else $error("data pin value not zero");
   a_los_drive_zero: assert property (rx_signal_lost_output_o == !rx_signal_lost_oe_o)
      else $error("loss pin value not zero");
   a_oe_after_fall: assert property ($changed(sda_oe_o) |-> fall_q <= 12'h006)
      else $error("data drive changed away from clock fall");
   a_oe_holds: assert property ($changed(sda_oe_o) |=> $stable(sda_oe_o)[*3])
      else $error("data drive not held");
   a_los_assert: assert property (on_q >= 12'h09c4 |-> !rx_signal_lost_oe_o)
      else $error("loss not flagged in time");
   a_los_release: assert property (off_q >= 12'h09c4 |-> rx_signal_lost_oe_o)
      else $error("loss not cleared in time");
   a_los_filter: assert property ($fell(rx_signal_lost_oe_o) |-> on_q >= 12'h07d0)
      else $error("loss flagged on a short glitch");
   c_ack: cover property ($rose(sda_oe_o));
   c_lost: cover property ($fell(rx_signal_lost_oe_o));
   c_back: cover property ($rose(rx_signal_lost_oe_o));
endmodule : serial_id_checker
bind module_serial_id_memory serial_id_checker chk (.sys_clk_i, .rst_i, .scl_i, .sda_i, .sda_o,
   .sda_oe_o, .present_n_o, .signal_lost_flag_i, .rx_signal_lost_output_o, .rx_signal_lost_oe_o);

// *** sid_defs.svh ***
// Constants for the serial identification memory block.
// Assumes inclusion by the design file and the bench; no logic here.
`ifndef SID_DEFS_SVH
`define SID_DEFS_SVH
`define SID_DEV_ADDR 7'h50
`define SID_MEM_DEPTH 128
`define SID_AW 7
`define SID_SPACE 8'h20
`define SID_ZERO 8'h00
`define SID_PIN_IDLE 1'b1
`define SID_LOS_IDLE 1'b0
`define SID_OFF_TYPE 7'h00
`define SID_OFF_EXT 7'h01
`define SID_OFF_CONN 7'h02
`define SID_OFF_COMPAT 7'h03
`define SID_OFF_ENC 7'h0b
`define SID_OFF_RATE 7'h0c
`define SID_OFF_RSVD13 7'h0d
`define SID_OFF_SM_KM 7'h0e
`define SID_OFF_SM_100M 7'h0f
`define SID_OFF_MMA 7'h10
`define SID_OFF_MMB 7'h11
`define SID_OFF_CU 7'h12
`define SID_OFF_PROT_END 7'h5f
`define SID_VAL_TYPE 8'h03
`define SID_VAL_EXT 8'h04
`define SID_VAL_CONN 8'h07
`define SID_VAL_COMPAT 64'h0000_0000_0000_0010
`define SID_VAL_ENC 8'h06
`define SID_VAL_RATE 8'h67
`define SID_VAL_SM_KM 8'h0a
`define SID_VAL_SM_100M 8'h64
`define SID_VAL_MMA 8'h00
`define SID_VAL_MMB 8'h00
`define SID_VAL_CU 8'h00
`define SID_LOS_TIME_US 100
`define SID_CLK_MHZ 25
`define SID_LOS_CYC ((`SID_LOS_TIME_US * `SID_CLK_MHZ) - 4)
`define SID_LOS_CW 12
`endif

// *** sid_pkg.sv ***
// Types for the serial identification memory block.
// Assumes sid_defs.svh for numeric constants.
package sid_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_DEVADDR, ST_ADDR, ST_WDATA, ST_RDATA, ST_ACK_OUT, ST_ACK_IN
   } sid_state_e;
endpackage : sid_pkg

// *** tb_module_serial_id_memory.sv ***
// Self-checking bench for the serial id memory block.
// Assumes the host model owns the bus clock and data pins.
`timescale 1ns/1ps
`include "sid_defs.svh"
module tb_module_serial_id_memory;
   logic sys_clk_i, rst_i, lost_flag, scl, sda, sda_oe, los_oe, los_out, sda_val, present_n;
   logic [7:0] scratch = 8'h00;
   int miscompares = 0;
   int samples_checked = 0;
   bus_host_model host (.sys_clk_i, .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
   module_serial_id_memory DUT (.sys_clk_i, .rst_i, .scl_i(scl), .sda_i(sda), .sda_o(sda_val),
      .sda_oe_o(sda_oe), .present_n_o(present_n), .signal_lost_flag_i(lost_flag),
      .rx_signal_lost_output_o(los_out), .rx_signal_lost_oe_o(los_oe));
   initial begin
      sys_clk_i = 1'b0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   function automatic logic [7:0] expect_byte(input int a);
      logic [63:0] c;
      c = `SID_VAL_COMPAT;
      case (a)
         0: return `SID_VAL_TYPE;
         1: return 8'h04;
         2: return `SID_VAL_CONN;
         11: return `SID_VAL_ENC;
         12: return `SID_VAL_RATE;
         14: return `SID_VAL_SM_KM;
         15: return `SID_VAL_SM_100M;
         16: return `SID_VAL_MMA;
         17: return `SID_VAL_MMB;
         18: return `SID_VAL_CU;
         100: return scratch;
         default: return (a > 2 && a < 11) ? c[8 * (10 - a) +: 8] : `SID_ZERO;
      endcase
   endfunction : expect_byte
   task automatic send(input logic [7:0] b, input logic nack_exp);
      logic [7:0] r;
      logic ack;
      host.xfer(b, 1'b1, r, ack);
      check({7'h00, ack}, {7'h00, nack_exp});
   endtask : send
   task automatic read_run(input int a, input int n);
      logic [7:0] d;
      logic ack;
      host.frame(1'b0);
      send(8'ha0, 1'b0);
      send(a[7:0], 1'b0);
      host.frame(1'b0);
      send(8'ha1, 1'b0);
      for (int i = 0; i < n; i++) begin
         host.xfer(8'hff, i == n - 1, d, ack);
         check(d, expect_byte(a + i));
      end
      host.frame(1'b1);
   endtask : read_run
   task automatic write_byte(input logic [7:0] a, input logic [7:0] v);
      host.frame(1'b0);
      send(8'ha0, 1'b0);
      send(a, 1'b0);
      send(v, 1'b0);
      host.frame(1'b1);
   endtask : write_byte
   task automatic test_field_map();
      read_run(0, 19);
      read_run(12, 2);
      read_run(95, 1);
      check({7'h00, present_n}, 8'h00);
      $display("field map test done");
   endtask : test_field_map
   task automatic test_wrong_device();
      logic [7:0] d;
      logic ack;
      host.frame(1'b0);
      send(8'ha2, 1'b1);
      host.frame(1'b1);
      read_run(0, 1);
      host.frame(1'b0);
      send(8'ha1, 1'b0);
      host.xfer(8'hff, 1'b1, d, ack);
      check(d, expect_byte(1));
      host.frame(1'b1);
      $display("wrong device test done");
   endtask : test_wrong_device
   task automatic test_protect();
      write_byte(8'h01, 8'h55);
      read_run(1, 1);
      write_byte(8'h64, 8'h5a);
      scratch = 8'h5a;
      read_run(100, 1);
      $display("protect test done");
   endtask : test_protect
   task automatic los_step(input logic lvl);
      int n;
      n = 0;
      lost_flag <= lvl;
      while (los_oe !== ~lvl && n < 2600) begin
         @(posedge sys_clk_i);
         n++;
      end
      check({7'h00, n <= 2500}, 8'h01);
      check({7'h00, los_out}, {7'h00, lvl});
      if (n == 2600) tally_and_finish();
      else repeat (200) @(posedge sys_clk_i);
   endtask : los_step
   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      rst_i = 1'b1;
      lost_flag = 1'b0;
      repeat (5) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      test_field_map();
      test_wrong_device();
      test_protect();
      los_step(1'b1);
      los_step(1'b0);
      $display("signal lost test done");
      tally_and_finish();
   end
endmodule : tb_module_serial_id_memory
